// ---- hdl/fhpi_defines.vh ----
// Constants shared by the flash host pin controller
`ifndef FHPI_DEFINES_VH
`define FHPI_DEFINES_VH

// -----------------------------------------------------------------
// Sector geometry
// -----------------------------------------------------------------
`define FHPI_MAIN_BYTES 12'd2048
`define FHPI_SPARE_BYTES 12'd64
`define FHPI_SECTOR_BYTES 12'd2112
`define FHPI_MARK_COL 12'h800
`define FHPI_MARK_LAST 12'h83f

// -----------------------------------------------------------------
// Command bytes
// -----------------------------------------------------------------
`define FHPI_CMD_READ 8'h00
`define FHPI_CMD_PROG 8'h10
`define FHPI_CMD_ERASE 8'h20
`define FHPI_CMD_PCONF 8'h40
`define FHPI_CMD_ECONF 8'hb0
`define FHPI_CMD_CLRST 8'h50

// -----------------------------------------------------------------
// Operation codes on the user port
// -----------------------------------------------------------------
`define FHPI_OP_READ 2'd0
`define FHPI_OP_PROG 2'd1
`define FHPI_OP_ERASE 2'd2
`define FHPI_OP_STAT 2'd3

// -----------------------------------------------------------------
// Timing, in clock cycles at 100 MHz (FHPI_STROBE_NS in ns), and program buffer size
// -----------------------------------------------------------------
`define FHPI_STROBE_NS 20
`define FHPI_STROBE_CYC 4'd2
`define FHPI_SCK_HALF 4'd4
`define FHPI_FIFO_DEPTH 16
`define FHPI_FIFO_AW 4

`endif

// ---- hdl/fhpi_fifo.v ----
// Parameterised first-in first-out buffer on flip-flops
`timescale 1ns/10ps
`default_nettype none
module fhpi_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Write side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // Read side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    // -------------------------------------------------------------
    // Storage and pointers
    // -------------------------------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage
    reg [AW-1:0] wr_ptr; // Write index
    reg [AW-1:0] rd_ptr; // Read index
    reg [AW:0] count; // Words held
    wire do_wr = i_in_valid && o_in_ready;
    wire do_rd = o_out_valid && i_out_ready;
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr];

    // Pointer and count update
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end

    // Word write
    always @(posedge i_clk)
    begin
        if (do_wr)
            mem[wr_ptr] <= i_in_data;
    end
endmodule
`default_nettype wire

// ---- hdl/fhpi_host.v ----
// Host controller driving the flash byte bus, strobes and serial clock
//
// Contract
// RULE1: Whole sector is the program/erase unit
// RULE2: Device buffer holds one full sector
// RULE3: Chip select rise ends a read
// RULE4: Busy operation survives chip select rise
// RULE5: Device drives bus only with OE low
// RULE6: Command/address captured on write strobe rise
// RULE7: Data moves on serial clock rise
// RULE8: Select low for command/data, high address
// RULE9: Hold guard low through power transitions
// RULE10: Guard high during every operation
// RULE11: Ready/busy pulled low after confirm byte
// RULE12: Ready/busy released when operation completes
// RULE13: Power-on default is status read
// RULE14: Operations only after command sequence
// RULE15: Save validity marker before erase
// RULE16: Write saved marker back on program
// RULE17: Host corrects multiple bit errors (the code passes read bytes on uncorrected)
// RULE18: Bus undriven when OE and WE high
`include "fhpi_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module fhpi_host (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // User command port
    input wire i_power_good,
    input wire i_cmd_valid,
    input wire [1:0] i_cmd_op,
    input wire [15:0] i_cmd_sector,
    output reg o_cmd_ready,
    output reg o_done,
    output reg [7:0] o_status,
    // User write data stream
    input wire i_wr_valid,
    input wire [7:0] i_wr_data,
    output wire o_wr_ready,
    // User read data stream
    output reg o_rd_valid,
    output reg [7:0] o_rd_data,
    input wire i_rd_ready,
    // Saved validity marker
    output reg [7:0] o_marker,
    // Flash pins
    output reg o_chip_sel_n,
    output reg o_out_en_n,
    output reg o_wr_strobe_n,
    output reg o_command_or_address_select,
    output reg o_serial_data_clock,
    output reg o_power_guard_n,
    output reg [7:0] o_byte_bus,
    output reg o_byte_bus_oe_n,
    input wire [7:0] i_byte_bus,
    input wire i_ready_busy
);
    // -------------------------------------------------------------
    // States
    // -------------------------------------------------------------
    localparam ST_OFF = 4'd0;
    localparam ST_IDLE = 4'd1;
    localparam ST_BYTE = 4'd2;
    localparam ST_STRB = 4'd3;
    localparam ST_PREP = 4'd4;
    localparam ST_SCKH = 4'd5;
    localparam ST_SCKL = 4'd6;
    localparam ST_WBSY = 4'd7;
    localparam ST_BUSY = 4'd8;
    localparam ST_STAT = 4'd9;
    localparam ST_END = 4'd10;

    reg [3:0] state; // Controller state
    reg [1:0] op; // Operation in progress
    reg [15:0] sector; // Sector address
    reg [2:0] seq; // Command sequence step
    reg [11:0] col; // Byte within sector
    reg [3:0] tmr; // Strobe and clock timer
    reg [7:0] mark_save; // Marker held across erase
    reg [1:0] rb_sync; // Ready/busy synchroniser
    reg [1:0] pg_sync; // Power good synchroniser
    reg [7:0] bus_s1; // Byte bus first stage
    reg [7:0] bus_s2; // Byte bus second stage
    reg fifo_pop; // Pop one program byte
    wire ff_valid; // Program byte available
    wire [7:0] ff_data; // Program byte
    wire rb_ready = rb_sync[1]; // High when released (pulled up)

    // -------------------------------------------------------------
    // Program data buffer
    // -------------------------------------------------------------
    fhpi_fifo #(
        .WIDTH(8),
        .DEPTH(`FHPI_FIFO_DEPTH),
        .AW(`FHPI_FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_wr_valid),
        .i_in_data(i_wr_data),
        .o_in_ready(o_wr_ready),
        .o_out_valid(ff_valid),
        .o_out_data(ff_data),
        .i_out_ready(fifo_pop)
    );

    // Sequence byte and select level for each step
    function [8:0] seq_byte;
        input [1:0] f_op;
        input [2:0] f_seq;
        input [15:0] f_sec;
        begin
            case (f_seq)
                3'd0: seq_byte = {1'b0, (f_op == `FHPI_OP_ERASE) ?
                    `FHPI_CMD_ERASE : (f_op == `FHPI_OP_PROG) ?
                    `FHPI_CMD_PROG : (f_op == `FHPI_OP_STAT) ?
                    `FHPI_CMD_CLRST : `FHPI_CMD_READ};
                3'd1: seq_byte = {1'b1, f_sec[7:0]};
                3'd2: seq_byte = {1'b1, f_sec[15:8]};
                default: seq_byte = {1'b0, (f_op == `FHPI_OP_ERASE) ?
                    `FHPI_CMD_ECONF : `FHPI_CMD_PCONF};
            endcase
        end
    endfunction

    wire [8:0] seq_word = seq_byte(op, seq, sector); // Select and byte

    // -------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rb_sync <= 2'b00;
            pg_sync <= 2'b00;
            bus_s1 <= 8'h00;
            bus_s2 <= 8'h00;
        end
        else
        begin
            rb_sync <= {rb_sync[0], i_ready_busy};
            pg_sync <= {pg_sync[0], i_power_good};
            bus_s1 <= i_byte_bus;
            bus_s2 <= bus_s1;
        end
    end

    // -------------------------------------------------------------
    // Main controller
    // -------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state <= ST_OFF;
            op <= 2'd0;
            sector <= 16'h0000;
            seq <= 3'd0;
            col <= 12'h000;
            tmr <= 4'h0;
            mark_save <= 8'hff;
            fifo_pop <= 1'b0;
            o_cmd_ready <= 1'b0;
            o_done <= 1'b0;
            o_status <= 8'h00;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_marker <= 8'hff;
            o_chip_sel_n <= 1'b1;
            o_out_en_n <= 1'b1;
            o_wr_strobe_n <= 1'b1;
            o_command_or_address_select <= 1'b0;
            o_serial_data_clock <= 1'b0;
            o_power_guard_n <= 1'b0; // [RULE9]
            o_byte_bus <= 8'h00;
            o_byte_bus_oe_n <= 1'b1;
        end
        else
        begin
            fifo_pop <= 1'b0;
            o_done <= 1'b0;
            if (o_rd_valid && i_rd_ready)
                o_rd_valid <= 1'b0;
            if (tmr != 4'h0)
                tmr <= tmr - 1'b1;
            case (state)
                // Guard held low until supply reported good
                ST_OFF:
                begin
                    o_power_guard_n <= pg_sync[1]; // [RULE9] [RULE10]
                    if (pg_sync[1])
                    begin
                        state <= ST_IDLE;
                        o_cmd_ready <= 1'b1;
                    end
                end
                // Wait for a user request; bus released
                ST_IDLE:
                begin
                    o_chip_sel_n <= 1'b1;
                    o_byte_bus_oe_n <= 1'b1; // [RULE18]
                    if (!pg_sync[1])
                    begin
                        o_power_guard_n <= 1'b0; // [RULE9]
                        o_cmd_ready <= 1'b0;
                        state <= ST_OFF;
                    end
                    else if (i_cmd_valid)
                    begin
                        o_cmd_ready <= 1'b0;
                        op <= i_cmd_op;
                        sector <= i_cmd_sector;
                        seq <= 3'd0;
                        col <= 12'h000;
                        o_chip_sel_n <= 1'b0;
                        state <= ST_BYTE;
                    end
                end
                // Put a sequence byte on the bus, strobe low
                ST_BYTE:
                begin
                    o_command_or_address_select <= seq_word[8]; // [RULE8]
                    o_byte_bus <= seq_word[7:0]; // [RULE14]
                    o_byte_bus_oe_n <= 1'b0;
                    o_wr_strobe_n <= 1'b0;
                    tmr <= `FHPI_STROBE_CYC;
                    state <= ST_STRB;
                end
                // Raise strobe; device latches on this rise
                ST_STRB:
                begin
                    if (tmr == 4'h0)
                    begin
                        o_wr_strobe_n <= 1'b1; // [RULE6]
                        seq <= seq + 1'b1;
                        if (op == `FHPI_OP_STAT || seq == 3'd3)
                            state <= (op == `FHPI_OP_STAT) ? ST_STAT : ST_WBSY;
                        else if (seq == 3'd2 && op != `FHPI_OP_ERASE)
                            state <= ST_PREP;
                        else
                            state <= ST_BYTE;
                    end
                end
                // Set up one serial byte (read or program)
                ST_PREP:
                begin
                    o_command_or_address_select <= 1'b0; // [RULE8]
                    if (op == `FHPI_OP_READ)
                    begin
                        o_byte_bus_oe_n <= 1'b1;
                        o_out_en_n <= 1'b0; // [RULE5]
                        if (!o_rd_valid)
                        begin
                            tmr <= `FHPI_SCK_HALF;
                            state <= ST_SCKH;
                        end
                    end
                    else if (col >= `FHPI_MARK_COL && col <= `FHPI_MARK_LAST)
                    begin
                        o_byte_bus <= mark_save; // [RULE16]
                        tmr <= `FHPI_SCK_HALF;
                        state <= ST_SCKH;
                    end
                    else if (ff_valid)
                    begin
                        o_byte_bus <= ff_data;
                        fifo_pop <= 1'b1;
                        tmr <= `FHPI_SCK_HALF;
                        state <= ST_SCKH;
                    end
                end
                // Serial clock high after setup
                ST_SCKH:
                begin
                    if (tmr == 4'h0)
                    begin
                        o_serial_data_clock <= 1'b1; // [RULE7]
                        tmr <= `FHPI_SCK_HALF;
                        state <= ST_SCKL;
                    end
                end
                // Serial clock low; sample read byte, step column
                ST_SCKL:
                begin
                    if (tmr == 4'h0)
                    begin
                        o_serial_data_clock <= 1'b0;
                        if (op == `FHPI_OP_READ)
                        begin
                            o_rd_data <= bus_s2; // [RULE17]
                            o_rd_valid <= 1'b1;
                            if (col >= `FHPI_MARK_COL &&
                                col <= `FHPI_MARK_LAST)
                                o_marker <= bus_s2; // [RULE15]
                        end
                        col <= col + 1'b1;
                        if (col == `FHPI_SECTOR_BYTES - 1'b1) // [RULE1]
                        begin
                            if (op == `FHPI_OP_READ)
                            begin
                                o_chip_sel_n <= 1'b1; // [RULE3]
                                o_out_en_n <= 1'b1;
                                state <= ST_END;
                            end
                            else
                                state <= ST_BYTE; // [RULE2]
                        end
                        else
                            state <= ST_PREP;
                    end
                end
                // Wait for busy to be seen after confirm byte
                ST_WBSY:
                begin
                    o_byte_bus_oe_n <= 1'b1;
                    o_chip_sel_n <= 1'b1; // [RULE4]
                    if (op == `FHPI_OP_ERASE)
                        mark_save <= o_marker; // [RULE15]
                    if (!rb_ready) // [RULE11]
                        state <= ST_BUSY;
                end
                // Wait for release of ready/busy
                ST_BUSY:
                begin
                    if (rb_ready) // [RULE12]
                    begin
                        op <= `FHPI_OP_STAT;
                        o_chip_sel_n <= 1'b0;
                        state <= ST_STAT;
                    end
                end
                // Read status byte with OE low
                ST_STAT:
                begin
                    o_byte_bus_oe_n <= 1'b1;
                    o_out_en_n <= 1'b0; // [RULE13]
                    if (tmr == 4'h0 && !o_out_en_n)
                    begin
                        o_status <= bus_s2;
                        o_out_en_n <= 1'b1;
                        o_chip_sel_n <= 1'b1;
                        state <= ST_END;
                    end
                    else if (o_out_en_n)
                        tmr <= `FHPI_SCK_HALF;
                end
                // Report completion once the last read byte is taken
                ST_END:
                begin
                    if (!o_rd_valid)
                    begin
                        o_done <= 1'b1;
                        o_cmd_ready <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_OFF;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verification/fhpi_flash_model.sv ----
// Behavioural model of the sector flash device on the pin side
`timescale 1ns/10ps
`default_nettype none
module fhpi_flash_model #(
    parameter int BUSY_NS = 3000,
    parameter logic [7:0] STAT_OK = 8'h80
) (
    // Pins from the host
    input wire logic i_chip_sel_n,
    input wire logic i_out_en_n,
    input wire logic i_wr_strobe_n,
    input wire logic i_cmd_addr_sel,
    input wire logic i_sclk,
    input wire logic i_guard_n,
    input wire logic [7:0] i_bus,
    // Pins back to the host
    output logic o_drive,
    output logic [7:0] o_bus,
    output logic o_busy
);
    logic [7:0] mem [0:2111]; // One sector with spare area
    logic [7:0] buff [0:2111]; // Sector transfer buffer
    logic [7:0] last_cmd = 8'hff; // Last command byte
    logic [15:0] sector; // Latched sector address
    logic [1:0] acnt = 2'h0; // Address bytes seen
    logic reading = 1'b0; // Serial read under way
    logic [7:0] rdata = 8'h00; // Current read byte
    int ptr = 0; // Serial byte pointer

    // Preset array contents
    initial
    begin
        o_busy = 1'b0;
        for (int i = 0; i < 2112; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end

    // Busy after an accepted confirm byte, released later
    task start_busy(input logic erase);
        o_busy = 1'b1;
        if (erase)
            foreach (mem[i]) mem[i] = 8'hff;
        else
            mem = buff;
        fork
            #(BUSY_NS) o_busy = 1'b0;
        join_none
    endtask

    // Bytes latched on the strobe rise, select picks kind
    always @(posedge i_wr_strobe_n)
        if (i_guard_n && !i_chip_sel_n)
        begin
            if (!i_cmd_addr_sel)
            begin
                // Confirm only after its own sequence
                if ((i_bus == 8'h40 && last_cmd == 8'h10) ||
                    (i_bus == 8'hb0 && last_cmd == 8'h20))
                    start_busy(i_bus == 8'hb0);
                last_cmd = i_bus;
                acnt = 2'h0;
                ptr = 0;
            end
            else
            begin
                if (acnt == 2'h0)
                    sector[7:0] = i_bus;
                else
                    sector[15:8] = i_bus;
                acnt++;
                reading = last_cmd == 8'h00 && acnt == 2'h2;
            end
        end

    // Program bytes taken, read bytes advanced on SC rise
    always @(posedge i_sclk)
        if (i_guard_n && !i_chip_sel_n && ptr < 2112)
        begin
            if (last_cmd == 8'h10)
                buff[ptr] = i_bus;
            rdata = mem[ptr];
            ptr++;
        end

    // Select rise ends a read; a busy operation carries on
    always @(posedge i_chip_sel_n)
        reading = 1'b0;

    // Guard low forces deep standby
    always @(negedge i_guard_n)
    begin
        reading = 1'b0;
        last_cmd = 8'hff;
    end

    // Drive only with CS and OE low; status by default
    assign o_drive = i_guard_n && !i_chip_sel_n && !i_out_en_n;
    assign o_bus = reading ? rdata : STAT_OK;
endmodule
`default_nettype wire

// ---- verification/fhpi_host_props.sv ----
// Concurrent checks on the pin and user sides of the flash host controller
`timescale 1ns/10ps
`default_nettype none
module fhpi_host_props (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // User command side
    input wire i_cmd_valid,
    input wire o_cmd_ready,
    input wire o_done,
    // Flash pins
    input wire o_chip_sel_n,
    input wire o_out_en_n,
    input wire o_wr_strobe_n,
    input wire o_command_or_address_select,
    input wire o_serial_data_clock,
    input wire o_power_guard_n,
    input wire [7:0] o_byte_bus,
    input wire o_byte_bus_oe_n,
    input wire i_ready_busy
);
    // -----------------------------------------------------------------
    // One clock domain, reset masks every check but the first
    // -----------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    guard_in_reset_a: assert property (disable iff (1'b0)
        i_sys_rst |=> !o_power_guard_n && o_chip_sel_n)
        else $error("guard not low in reset");
    guard_ops_a: assert property (!o_chip_sel_n |-> o_power_guard_n)
        else $error("chip selected with guard low");
    no_contend_a: assert property (!o_byte_bus_oe_n |-> o_out_en_n)
        else $error("host drives bus while output enabled");
    strobe_quiet_a: assert property (!o_wr_strobe_n |-> o_out_en_n)
        else $error("write strobe with output enable");
    strobe_data_a: assert property ($rose(o_wr_strobe_n) |->
        $stable(o_byte_bus) && $stable(o_command_or_address_select))
        else $error("bus moved at write strobe rise");
    sck_frame_a: assert property (o_serial_data_clock |->
        !o_chip_sel_n && o_wr_strobe_n && !o_command_or_address_select)
        else $error("serial clock outside a data frame");
    busy_quiet_a: assert property (!i_ready_busy |->
        o_wr_strobe_n && o_out_en_n)
        else $error("access while device busy");
    ready_done_a: assert property ($rose(i_ready_busy) |->
        ##[1:60] o_done)
        else $error("no completion after ready");
    take_once_a: assert property (o_cmd_ready && i_cmd_valid |=>
        !o_cmd_ready)
        else $error("request not taken");
    done_pulse_a: assert property (o_done |-> o_cmd_ready ##1 !o_done)
        else $error("done not a single pulse");
endmodule

bind fhpi_host fhpi_host_props u_props (
    .i_clk, .i_sys_rst, .i_cmd_valid, .o_cmd_ready, .o_done,
    .o_chip_sel_n, .o_out_en_n, .o_wr_strobe_n,
    .o_command_or_address_select, .o_serial_data_clock,
    .o_power_guard_n, .o_byte_bus, .o_byte_bus_oe_n, .i_ready_busy);
`default_nettype wire

// ---- verification/fhpi_host_test.sv ----
// Self-checking bench for the flash host pin controller
`timescale 1ns/10ps
`default_nettype none
module fhpi_host_test;
    localparam logic [7:0] STAT = 8'h80; // Status of an idle device
    logic clk = 1'b0, rst = 1'b1, pgood = 1'b0; // Clock, reset, supply
    logic cmd_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [15:0] cmd_sector = 16'h0000;
    logic [7:0] wr_data = 8'h00, last_bus = 8'h00;
    logic [7:0] host_bus, dev_bus, wire_bus, status, rd_data, marker;
    logic cmd_ready, done, rd_valid, wr_ready, cs_n, oe_n, we_n, cas;
    logic sclk, guard_n, bus_oe_n, drive, busy;
    logic [7:0] img [0:2111]; // Expected sector image
    logic [7:0] got [0:2111]; // Bytes read back
    int errors = 0, num_checks = 0, nrd, nwr;

    // Bus level: active driver, else inverse of the last level
    assign wire_bus = !bus_oe_n ? host_bus : drive ? dev_bus : ~last_bus;
    always @(posedge clk) last_bus <= wire_bus;
    initial forever #5 clk = ~clk;

    fhpi_host u_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_power_good(pgood),
        .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
        .i_cmd_sector(cmd_sector), .o_cmd_ready(cmd_ready),
        .o_done(done), .o_status(status), .i_wr_valid(wr_valid),
        .i_wr_data(wr_data), .o_wr_ready(wr_ready),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .i_rd_ready(rd_ready), .o_marker(marker),
        .o_chip_sel_n(cs_n), .o_out_en_n(oe_n), .o_wr_strobe_n(we_n),
        .o_command_or_address_select(cas), .o_serial_data_clock(sclk),
        .o_power_guard_n(guard_n), .o_byte_bus(host_bus),
        .o_byte_bus_oe_n(bus_oe_n), .i_byte_bus(wire_bus),
        .i_ready_busy(!busy));
    fhpi_flash_model #(.STAT_OK(STAT)) u_flash (
        .i_chip_sel_n(cs_n), .i_out_en_n(oe_n), .i_wr_strobe_n(we_n),
        .i_cmd_addr_sel(cas), .i_sclk(sclk), .i_guard_n(guard_n),
        .i_bus(host_bus), .o_drive(drive), .o_bus(dev_bus),
        .o_busy(busy));

    function automatic logic [7:0] pat(input int n);
        return 8'(n * 7 + 3);
    endfunction

    task automatic check8(input string what, input logic [7:0] exp, seen);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Issue one operation, feed or collect bytes until done
    task automatic run_op(input logic [1:0] op, input logic [15:0] sec);
        int cyc, hold;
        logic wtook, rtook;
        logic [7:0] rbyte;
        cyc = 0;
        hold = 0;
        nrd = 0;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_sector = sec;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        while (done !== 1'b1 && cyc < 40000)
        begin
            @(negedge clk);
            wtook = wr_valid && wr_ready;
            rtook = rd_valid && rd_ready;
            rbyte = rd_data;
            @(posedge clk);
            #1 cyc++;
            if (rtook)
                got[nrd++] = rbyte;
            if (wtook)
                nwr++;
            // Stall the write stream now and then so the buffer drains
            if (wtook && nwr % 512 == 0)
                hold = 40;
            if (hold > 0)
                hold--;
            wr_valid = op == 2'h1 && hold == 0;
            wr_data = pat(nwr);
            rd_ready = cyc % 8 != 0;
        end
        check8("completion", 8'h01, {7'h00, done});
    endtask

    task automatic t_power();
        repeat (10) @(posedge clk);
        #1 check8("guard off", 8'h00, {7'h00, guard_n});
        check8("idle off", 8'h00, {7'h00, cmd_ready});
        pgood = 1'b1;
        repeat (12) @(posedge clk);
        #1 check8("guard on", 8'h01, {7'h00, guard_n});
        check8("idle on", 8'h01, {7'h00, cmd_ready});
        $display("test power done");
    endtask

    task automatic t_status();
        run_op(2'h3, 16'h0000);
        check8("status", STAT, status);
        $display("test status done");
    endtask

    task automatic t_read(input logic [15:0] sec);
        run_op(2'h0, sec);
        check8("count high", 8'h08, 8'(nrd >> 8));
        check8("count low", 8'h40, 8'(nrd));
        for (int i = 0; i < 2112; i++)
            check8("read byte", img[i], got[i]);
        check8("sector low", sec[7:0], u_flash.sector[7:0]);
        check8("sector high", sec[15:8], u_flash.sector[15:8]);
        check8("marker", img[2111], marker);
        check8("read ended", 8'h00, {7'h00, u_flash.reading});
        $display("test read done");
    endtask

    task automatic t_erase();
        run_op(2'h2, 16'h1234);
        check8("erased", 8'hff, u_flash.mem[0]);
        check8("status", STAT, status);
        $display("test erase done");
    endtask

    task automatic t_program();
        logic took;
        nwr = 0;
        wr_valid = 1'b1;
        wr_data = pat(0);
        // Fill the buffer until it refuses
        repeat (20)
        begin
            @(negedge clk);
            took = wr_ready;
            @(posedge clk);
            #1 nwr += int'(took);
            wr_data = pat(nwr);
        end
        check8("buffer fill", 8'h10, 8'(nwr));
        check8("buffer full", 8'h00, {7'h00, wr_ready});
        run_op(2'h1, 16'h1234);
        wr_valid = 1'b0;
        check8("status", STAT, status);
        // Data columns from the stream, spare holds the saved marker
        for (int i = 0; i < 2112; i++)
            img[i] = i < 2048 ? pat(i) : 8'h65;
        $display("test program done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        for (int i = 0; i < 2112; i++)
            img[i] = 8'(i) ^ 8'h5a;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_power();
        t_status();
        t_read(16'h1234);
        t_erase();
        t_program();
        t_read(16'h1234);
        report_and_stop();
    end

    // Cut a hang short: the run needs about 0.8 ms
    initial
    begin
        #950_000;
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
